// File: src/sgc_pkg.sv
// Package for the serializer general configuration register bank
package sgc_pkg;

  // Register offsets on the local register port
  localparam logic [7:0] SGC_ADDR_GEN_CFG = 8'h03;
  localparam logic [7:0] SGC_ADDR_RSVD    = 8'h04;

  // Field positions of the general configuration register
  localparam int SGC_BIT_CRC_CHECK_EN  = 7;
  localparam int SGC_BIT_PARITY_GEN_EN = 6;
  localparam int SGC_BIT_CRC_CNT_CLR   = 5;
  localparam int SGC_BIT_AUTO_ACK      = 4;
  localparam int SGC_BIT_PASS_ALL      = 3;
  localparam int SGC_BIT_PASS_THROUGH  = 2;
  localparam int SGC_BIT_PLL_OVERRIDE  = 1;
  localparam int SGC_BIT_PIXEL_EDGE    = 0;

  // Reset value: checker, parity, pass-through and rising edge enabled
  localparam logic [7:0] SGC_GEN_CFG_RESET = 8'hC5;
  localparam logic [7:0] SGC_RSVD_READ     = 8'h00;
  localparam logic [7:0] SGC_BYTE_ZERO     = 8'h00;

  // A zero alias or remote target identifier disables the matching path
  localparam logic [6:0] SGC_ID_NONE = 7'h00;

  // Synchroniser depth for pins
  localparam int SGC_SYNC_STAGES = 2;

  // Decoded view of the configuration register
  typedef struct packed {
    logic crc_check_en;
    logic parity_gen_en;
    logic crc_cnt_clear;
    logic auto_ack_en;
    logic pass_all;
    logic pass_through;
    logic pll_source_override;
    logic pixel_edge_select;
  } sgc_cfg_t;

  // Identifiers used for forwarding decisions
  typedef struct packed {
    logic [6:0] own_id;
    logic [6:0] remote_target_identifier;
    logic [6:0] des_alias;
    logic [6:0] target_alias;
    logic [6:0] target_id;
  } sgc_ids_t;

  // Incoming local I2C transaction header
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
  } sgc_txn_t;

  // Forwarding decision for the control channel
  typedef struct packed {
    logic       valid;
    logic       forward;
    logic       write;
    logic       auto_ack;
    logic [6:0] addr;
  } sgc_fwd_t;

  // Forwarding path selected for a transaction
  typedef enum logic [1:0] {
    SGC_PATH_NONE,
    SGC_PATH_DES,
    SGC_PATH_TARGET
  } sgc_path_t;

endpackage

// File: src/sgc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sgc_sync
  import sgc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: src/sgc_general_config.sv
// General configuration register bank and I2C forwarding decision
`timescale 1ns/1ns
// Functional notes
// - Back-channel CRC checking runs only while bit 7 is set.
// - Forward-channel parity is inserted only while bit 6 is set.
// - Bit 5 holds CRC error counters cleared until software writes zero.
// - Auto acknowledge applies only while the link reports lock.
// - Auto-acknowledged writes go to the remote target identifier address.
// - Bit 3 remaps every non-own access to the remote target identifier, forwarding it only if that identifier is nonzero.
// - Bit 2 forwards accesses hitting the deserializer alias or target alias.
// - Bit 1 set takes PLL source from the register setting, ignoring the strap.
// - Bit 1 clear takes PLL source only from the mode strap.
// - Bit 0 one samples pixels on rising edge, zero on falling edge.
// - Deserializer alias hits are remapped to the remote target identifier.
module sgc_general_config
  import sgc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       link_lock,
  input  wire logic       mode_strap,
  input  wire logic       pll_source_reg,
  input  wire sgc_ids_t   ids,
  input  wire sgc_txn_t   txn,
  output sgc_fwd_t        fwd,
  output logic            crc_check_en,
  output logic            parity_gen_en,
  output logic            crc_cnt_clear,
  output logic            pll_source_ext,
  output logic            pixel_edge_rising
);

  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  sgc_fwd_t   fwd_q;
  sgc_fwd_t   fwd_d;
  logic       pll_src_q;
  logic       pll_src_d;
  logic       lock_s;
  logic       strap_s;
  sgc_cfg_t   cfg;
  sgc_path_t  path;
  logic       wr_cfg;
  logic       rd_cfg;
  logic       rd_rsvd;
  logic       own_hit;
  logic       des_hit;
  logic       tgt_hit;
  logic       ack_ok;

  // Lock and strap share one synchroniser instance
  localparam int PIN_COUNT = 2;

  // Pins come from outside the clock domain
  sgc_sync #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({link_lock, mode_strap}),
    .sync_out ({lock_s, strap_s})
  );

  // Alias match, where a zero alias never matches
  function automatic logic alias_hit(input logic [6:0] alias_id, input logic [6:0] addr);
    alias_hit = (alias_id != SGC_ID_NONE) && (alias_id == addr);
  endfunction

  // Register address decode, shared by the write and read strobes
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction

  // Field view of the register, in bit order
  always_comb begin
    cfg.crc_check_en        = cfg_q[SGC_BIT_CRC_CHECK_EN];
    cfg.parity_gen_en       = cfg_q[SGC_BIT_PARITY_GEN_EN];
    cfg.crc_cnt_clear       = cfg_q[SGC_BIT_CRC_CNT_CLR];
    cfg.auto_ack_en         = cfg_q[SGC_BIT_AUTO_ACK];
    cfg.pass_all            = cfg_q[SGC_BIT_PASS_ALL];
    cfg.pass_through        = cfg_q[SGC_BIT_PASS_THROUGH];
    cfg.pll_source_override = cfg_q[SGC_BIT_PLL_OVERRIDE];
    cfg.pixel_edge_select   = cfg_q[SGC_BIT_PIXEL_EDGE];
  end

  // Strobe decode for the register port
  always_comb begin
    wr_cfg  = reg_wr && addr_is(reg_addr, SGC_ADDR_GEN_CFG);
    rd_cfg  = reg_rd && addr_is(reg_addr, SGC_ADDR_GEN_CFG);
    rd_rsvd = reg_rd && addr_is(reg_addr, SGC_ADDR_RSVD);
  end

  // Register port: write takes effect next edge, read data registered
  // A read in the cycle of a write returns the old value
  always_comb begin
    cfg_d    = cfg_q;
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    // Writes to any other byte, the reserved one included, fall away
    if (wr_cfg) begin
      cfg_d = reg_wdata;
    end
    if (rd_cfg) begin
      rdata_d = cfg_q;
    end else if (rd_rsvd) begin
      rdata_d = SGC_RSVD_READ;
    end else if (reg_rd) begin
      rdata_d = SGC_BYTE_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q    <= SGC_GEN_CFG_RESET;
      rdata_q  <= SGC_BYTE_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Header matches; a zero alias is never a hit
  always_comb begin
    own_hit = (txn.addr == ids.own_id);
    des_hit = alias_hit(ids.des_alias, txn.addr);
    tgt_hit = alias_hit(ids.target_alias, txn.addr);
  end

  // Path choice; own address always stays local
  always_comb begin
    path = SGC_PATH_NONE;
    if (own_hit) begin
      path = SGC_PATH_NONE;
    end else if (cfg.pass_all) begin
      path = SGC_PATH_DES;
    end else if (cfg.pass_through && des_hit) begin
      path = SGC_PATH_DES;
    end else if (cfg.pass_through && tgt_hit) begin
      path = SGC_PATH_TARGET;
    end
  end

  // Early acknowledge only on a locked link, only for the deserializer path
  always_comb begin
    ack_ok = cfg.auto_ack_en && lock_s && (path == SGC_PATH_DES);
  end

  // Forwarding decision, registered one edge after the header
  always_comb begin
    fwd_d          = '0;
    fwd_d.valid    = txn.valid;
    fwd_d.write    = txn.write;
    fwd_d.addr     = txn.addr;
    // Only the address may be remapped; the other header fields pass through
    case (path)
      SGC_PATH_DES: begin
        // A zero identifier disables remote deserializer access
        fwd_d.forward = txn.valid && (ids.remote_target_identifier != SGC_ID_NONE);
        fwd_d.addr    = ids.remote_target_identifier;
      end
      SGC_PATH_TARGET: begin
        fwd_d.forward = txn.valid;
        fwd_d.addr    = ids.target_id;
      end
      default: begin
        fwd_d.forward = 1'b0;
      end
    endcase
    fwd_d.auto_ack = fwd_d.forward && txn.write && ack_ok;
  end

  // Override trades strap robustness for software control
  always_comb begin
    if (cfg.pll_source_override) begin
      pll_src_d = pll_source_reg;
    end else begin
      pll_src_d = strap_s;
    end
  end

  // Forwarding decision stands for exactly one cycle per header
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_q <= '0;
    end else begin
      fwd_q <= fwd_d;
    end
  end

  // Registered so a strap change never reaches the PLL mux mid-cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_src_q <= 1'b0;
    end else begin
      pll_src_q <= pll_src_d;
    end
  end

  // Every output comes straight from a flip-flop
  assign reg_rdata         = rdata_q;
  assign reg_rvalid        = rvalid_q;
  assign fwd               = fwd_q;
  assign crc_check_en      = cfg_q[SGC_BIT_CRC_CHECK_EN];
  assign parity_gen_en     = cfg_q[SGC_BIT_PARITY_GEN_EN];
  assign crc_cnt_clear     = cfg_q[SGC_BIT_CRC_CNT_CLR];
  assign pll_source_ext    = pll_src_q;
  assign pixel_edge_rising = cfg_q[SGC_BIT_PIXEL_EDGE];

endmodule

// File: sim/sgc_general_config_properties.sv
// Checker for the general configuration register bank
`timescale 1ns/1ns
module sgc_general_config_properties
  import sgc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       link_lock,
  input wire logic       mode_strap,
  input wire logic       pll_source_reg,
  input wire sgc_ids_t   ids,
  input wire sgc_txn_t   txn,
  input wire sgc_fwd_t   fwd,
  input wire logic       crc_check_en,
  input wire logic       parity_gen_en,
  input wire logic       crc_cnt_clear,
  input wire logic       pll_source_ext,
  input wire logic       pixel_edge_rising
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire cw = reg_wr && reg_addr == SGC_ADDR_GEN_CFG;
  sequence s_ovr_on;
    cw && reg_wdata[SGC_BIT_PLL_OVERRIDE] ##1 (!reg_wr) [*2];
  endsequence
  // Strap passes two sync stages, so it must sit still for four cycles
  sequence s_strap_sel;
    cw && !reg_wdata[SGC_BIT_PLL_OVERRIDE] ##1 ($stable(mode_strap) && !reg_wr) [*4];
  endsequence
  a_cfg_bits_follow: assert property (cw |=>
    {crc_check_en, parity_gen_en, crc_cnt_clear, pixel_edge_rising}
    == {$past(reg_wdata[7:5]), $past(reg_wdata[0])}) else $error("config outputs wrong");
  a_clear_bit_held: assert property (!cw |=> $stable(crc_cnt_clear)) else $error("clear bit moved");
  a_rsvd_reads_zero: assert property (reg_rd && reg_addr == SGC_ADDR_RSVD |=> reg_rvalid
    && reg_rdata == SGC_RSVD_READ) else $error("reserved read wrong");
  a_own_not_fwd: assert property (txn.valid && txn.addr == ids.own_id |=> fwd.valid && !fwd.forward)
    else $error("own access forwarded");
  a_nolock_no_ack: assert property ((!link_lock) [*3] ##0 txn.valid |=> !fwd.auto_ack)
    else $error("ack without lock");
  a_ack_target_id: assert property (fwd.valid && fwd.forward && fwd.auto_ack
    |-> fwd.addr == ids.remote_target_identifier) else $error("ack target wrong");
  a_ack_only_write: assert property (fwd.auto_ack |-> fwd.write && fwd.forward)
    else $error("ack on a read");
  a_pll_reg_src: assert property (s_ovr_on |-> pll_source_ext == $past(pll_source_reg))
    else $error("pll override wrong");
  a_pll_strap_src: assert property (s_strap_sel |-> pll_source_ext == mode_strap)
    else $error("pll strap wrong");
endmodule

// File: sim/sgc_remote_model.sv
// Far side model: link lock and mode strap pins
`timescale 1ns/1ns
module sgc_remote_model (
  input  wire logic lock_req,
  input  wire logic strap_req,
  output logic      link_lock,
  output logic      mode_strap
);
  // Pins move off the clock grid, as a real remote link would
  always @(lock_req) link_lock <= #7 lock_req;
  always @(strap_req) mode_strap <= #3 strap_req;
  initial begin
    link_lock = 1'h0;
    mode_strap = 1'h0;
  end
endmodule

// File: sim/tb_sgc_general_config.sv
// Testbench for the general configuration register bank
`timescale 1ns/1ns
module tb_sgc_general_config;
  import sgc_pkg::*;
  logic       mclk, rst_n, reg_wr, reg_rd, reg_rvalid, link_lock, mode_strap, pll_source_reg;
  logic       crc_check_en, parity_gen_en, crc_cnt_clear, pll_source_ext, pixel_edge_rising;
  logic       lock_req, strap_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  sgc_ids_t   ids;
  sgc_txn_t   txn;
  sgc_fwd_t   fwd;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  sgc_general_config uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_lock(link_lock),
    .mode_strap(mode_strap), .pll_source_reg(pll_source_reg), .ids(ids), .txn(txn), .fwd(fwd),
    .crc_check_en(crc_check_en), .parity_gen_en(parity_gen_en), .crc_cnt_clear(crc_cnt_clear),
    .pll_source_ext(pll_source_ext), .pixel_edge_rising(pixel_edge_rising));
  sgc_remote_model peer (.lock_req(lock_req), .strap_req(strap_req), .link_lock(link_lock),
    .mode_strap(mode_strap));
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge mclk) #1;
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge mclk) #1;
    reg_rd = 1'h0;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask
  task automatic cfg(input logic [7:0] d);
    chk({4'h0, crc_check_en, parity_gen_en, crc_cnt_clear, pixel_edge_rising}, {4'h0, d[7:5], d[0]});
  endtask
  task automatic tx(input logic [6:0] a, input logic w, input logic f, input logic k, input logic [6:0] m);
    @(posedge mclk) #1;
    txn = {1'h1, w, a};
    @(posedge mclk) #1;
    txn = '0;
    chk({5'h00, fwd.valid, fwd.forward, fwd.write}, {5'h00, 1'h1, f, w});
    if (f) chk({fwd.auto_ack, fwd.addr}, {k, m});
  endtask
  task automatic t_reset;
    cfg(8'hC5);
    rd(SGC_ADDR_GEN_CFG, 8'hC5);
  endtask
  // Second value writes zero to the clear bit, as software must
  task automatic t_cfg;
    logic [7:0] v [2] = '{8'h3A, 8'hC5};
    foreach (v[i]) begin
      wr(SGC_ADDR_GEN_CFG, v[i]);
      cfg(v[i]);
      rd(SGC_ADDR_GEN_CFG, v[i]);
    end
  endtask
  task automatic t_rsvd;
    wr(SGC_ADDR_RSVD, 8'hFF);
    rd(SGC_ADDR_RSVD, 8'h00);
    rd(SGC_ADDR_GEN_CFG, 8'hC5);
  endtask
  task automatic t_pll;
    wr(SGC_ADDR_GEN_CFG, 8'h06);
    pll_source_reg = 1'h1;
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, pll_source_ext}, 8'h01);
    pll_source_reg = 1'h0;
    strap_req = 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, pll_source_ext}, 8'h00);
    wr(SGC_ADDR_GEN_CFG, 8'h04);
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, pll_source_ext}, 8'h01);
    strap_req = 1'h0;
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, pll_source_ext}, 8'h00);
  endtask
  task automatic t_fwd;
    lock_req = 1'h1;
    repeat (4) @(posedge mclk);
    wr(SGC_ADDR_GEN_CFG, 8'h14);
    tx(7'h31, 1'h1, 1'h1, 1'h1, 7'h30);
    tx(7'h32, 1'h1, 1'h1, 1'h0, 7'h50);
    tx(7'h10, 1'h1, 1'h0, 1'h0, 7'h00);
    tx(7'h77, 1'h1, 1'h0, 1'h0, 7'h00);
    wr(SGC_ADDR_GEN_CFG, 8'h18);
    tx(7'h77, 1'h1, 1'h1, 1'h1, 7'h30);
    tx(7'h77, 1'h0, 1'h1, 1'h0, 7'h30);
    tx(7'h10, 1'h1, 1'h0, 1'h0, 7'h00);
    lock_req = 1'h0;
    repeat (4) @(posedge mclk);
    tx(7'h77, 1'h1, 1'h1, 1'h0, 7'h30);
    // A zero remote identifier shuts the deserializer path
    ids.remote_target_identifier = SGC_ID_NONE;
    tx(7'h77, 1'h1, 1'h0, 1'h0, 7'h00);
    ids.remote_target_identifier = 7'h30;
    wr(SGC_ADDR_GEN_CFG, 8'h00);
    tx(7'h31, 1'h1, 1'h0, 1'h0, 7'h00);
  endtask
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // Ceiling well above the 70 or so cycles the scenarios need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'h0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, pll_source_reg, lock_req, strap_req} = '0;
    txn = '0;
    ids = {7'h10, 7'h30, 7'h31, 7'h32, 7'h50};
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'h1;
    t_reset();
    t_cfg();
    t_rsvd();
    t_pll();
    t_fwd();
    summarize();
  end
endmodule
bind sgc_general_config sgc_general_config_properties chk_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .link_lock(link_lock), .mode_strap(mode_strap), .pll_source_reg(pll_source_reg), .ids(ids), .txn(txn),
  .fwd(fwd), .crc_check_en(crc_check_en), .parity_gen_en(parity_gen_en), .crc_cnt_clear(crc_cnt_clear),
  .pll_source_ext(pll_source_ext), .pixel_edge_rising(pixel_edge_rising));
